// ---- rtl/two_wire_unit.sv ----
// Byte-level two-wire unit with status codes, bus-error recovery and arbitration.
// Assumes an AHB-Lite master on hclk and open-drain SCL/SDA resolved outside.
//
// How it works
// - Status reads 0xF8 whenever the transfer-done flag is clear.
// - START or STOP inside a byte or acknowledge gives status 0x00.
// - A bus error sets the transfer-done flag.
// - Recovery enters not-addressed slave mode and clears only the stop request.
// - Recovery releases SDA and SCL and sends no STOP.
// - After a repeated START the master keeps the bus.
// - Driving one while the line reads zero means arbitration lost.
// - Arbitration may be lost in the direction bit or data bits.
// - Identical traffic from several masters sees no contention.
// - Losing in the address phase compares own address, enters slave modes.
// - An unaddressed loser goes idle slave or retries START as software chooses.
`timescale 1ns/10ps
`default_nettype none
module two_wire_unit
   import twbus_pkg::*;
#(
   parameter int HALF = twbus_pkg::HALF_CYCLES
)(
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire logic                    scl_in,
   input  wire logic                    sda_in,
   output twbus_pkg::pin_drive_s        pins,
   output logic                         irq
);
   import twbus_pkg::*;

   // Two-stage synchronisers; only the second stage is read by logic.
   logic [1:0] scl_s_q, sda_s_q;
   logic       scl_q, sda_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_s_q <= 2'b11;
         sda_s_q <= 2'b11;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_in};
         sda_s_q <= {sda_s_q[0], sda_in};
         scl_q   <= scl_s_q[1];
         sda_q   <= sda_s_q[1];
      end
   end
   wire scl_now   = scl_s_q[1];
   wire sda_now   = sda_s_q[1];
   wire scl_rise  = scl_now & ~scl_q;
   wire scl_fall  = ~scl_now & scl_q;
   wire start_det = scl_now & scl_q & sda_q & ~sda_now;
   wire stop_det  = scl_now & scl_q & ~sda_q & sda_now;

   // AHB-Lite address phase capture; zero wait states, always OKAY.
   logic       wr_q;
   logic [7:0] wa_q;
   wire        take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
      end else begin
         wr_q <= take & hwrite;
         wa_q <= haddr[7:0];
      end
   end
   wire wr_ctrl = wr_q & (wa_q == OFF_CTRL);
   wire wr_data = wr_q & (wa_q == OFF_DATA);
   wire wr_addr = wr_q & (wa_q == OFF_ADDR);
   wire wr_ien  = wr_q & (wa_q == OFF_IRQ_EN);
   wire wr_icl  = wr_q & (wa_q == OFF_IRQ_CL);
   wire go      = wr_ctrl & hwdata[CTL_DONE];

   // Block state.
   seq_e        st_q;
   logic        en_q, done_q, sta_q, sto_q, ack_q;
   logic [7:0]  code_q, data_q, sh_q;
   logic [6:0]  own_q;
   logic [3:0]  bit_q;
   logic        master_q, rx_q, addr_ph_q, busy_q, hold_q;
   logic        sda_oe_n_q, scl_oe_n_q;
   logic [15:0] tmr_q;
   logic [IRQ_W-1:0] ist_q, ien_q;
   wire         tick = (tmr_q == 16'h0000);
   wire [7:0]   stat = done_q ? code_q : ST_IDLE;
   // A frame condition during a byte or acknowledge bit is illegal.
   wire in_frame = (st_q == S_BIT) || (st_q == S_ACK) || (st_q == S_SBIT) || (st_q == S_SACK);
   wire bus_err  = en_q & in_frame & (start_det | stop_det);
   // Arbitration: we released SDA (drive one) yet sample zero on SCL high.
   wire arb_lost = master_q & ~rx_q & (st_q == S_BIT) & scl_rise & sda_oe_n_q & ~sda_now;

   // Read mux.
   logic [31:0] rd_d;
   always_comb begin
      rd_d = 32'h0000_0000;
      case (haddr[7:0])
         OFF_CTRL:   rd_d = {27'h0, ack_q, sto_q, sta_q, done_q, en_q};
         OFF_STATUS: rd_d = {24'h0, stat};
         OFF_DATA:   rd_d = {24'h0, data_q};
         OFF_ADDR:   rd_d = {25'h0, own_q};
         OFF_IRQ_ST: rd_d = {29'h0, ist_q};
         OFF_IRQ_EN: rd_d = {29'h0, ien_q};
         default:    rd_d = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hrdata    <= (take & ~hwrite) ? rd_d : hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Sticky interrupt status: hardware sets win over a same-cycle clear.
   // The hold pulse rises in the same cycle as each sequencer set of the done flag; a bus-error set gives none.
   wire done_set = bus_err | arb_lost | hold_q;
   wire [IRQ_W-1:0] iset = {arb_lost, bus_err, done_set};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ist_q <= '0;
         ien_q <= '0;
         irq   <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~(wr_icl ? hwdata[IRQ_W-1:0] : '0)) | iset;
         ien_q <= wr_ien ? hwdata[IRQ_W-1:0] : ien_q;
         irq   <= |(ist_q & ien_q);
      end
   end

   // Sequencer. The transfer-done flag freezes the bus with SCL low until software writes one, except after a bus error.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= S_IDLE;
         en_q <= 1'b0; done_q <= 1'b0; sta_q <= 1'b0; sto_q <= 1'b0; ack_q <= 1'b0;
         code_q <= ST_IDLE; data_q <= 8'h00; sh_q <= 8'h00; own_q <= 7'h00;
         bit_q <= 4'h0; master_q <= 1'b0; rx_q <= 1'b0; addr_ph_q <= 1'b0;
         busy_q <= 1'b0; hold_q <= 1'b0;
         sda_oe_n_q <= 1'b1; scl_oe_n_q <= 1'b1; tmr_q <= 16'h0000;
      end else begin
         tmr_q  <= tick ? 16'(HALF - 1) : tmr_q - 16'h0001;
         hold_q <= 1'b0;
         if (wr_data) data_q <= hwdata[7:0];
         if (wr_addr) own_q <= hwdata[6:0];
         if (wr_ctrl) begin
            en_q  <= hwdata[CTL_EN];
            sta_q <= hwdata[CTL_START];
            sto_q <= hwdata[CTL_STOP];
            ack_q <= hwdata[CTL_ACK];
         end
         // Done flag: write one clears; a hardware set in the same cycle wins.
         if (go) done_q <= 1'b0;
         if (bus_err) begin
            done_q <= 1'b1;
            code_q <= ST_BUS_ERR;
            st_q   <= S_WAIT;
            master_q <= 1'b0;
         end else if (arb_lost) begin
            // Release SDA at once, finish the byte as a listener.
            master_q <= 1'b0;
            code_q   <= ST_ARB_LOST;
            rx_q     <= 1'b1;
            sda_oe_n_q <= 1'b1;
            sh_q     <= {sh_q[6:0], sda_now};
            bit_q    <= bit_q + 4'h1;
            st_q     <= S_SBIT;
         end else begin
            case (st_q)
               S_IDLE: begin
                  sda_oe_n_q <= 1'b1;
                  scl_oe_n_q <= 1'b1;
                  busy_q <= 1'b0;
                  if (en_q & sta_q & scl_now & sda_now & tick) begin
                     st_q <= S_START;
                     master_q <= 1'b1;
                  end else if (en_q & start_det) begin
                     st_q <= S_SLV;
                  end
               end
               S_WAIT: begin
                  // Stretch SCL while software owns the next decision, except after a bus error.
                  if (code_q != ST_BUS_ERR) scl_oe_n_q <= 1'b0;
                  if (go & (code_q == ST_BUS_ERR) & hwdata[CTL_STOP] & ~hwdata[CTL_START]) begin
                     sto_q <= 1'b0;
                     sda_oe_n_q <= 1'b1;
                     scl_oe_n_q <= 1'b1;
                     master_q <= 1'b0;
                     st_q <= S_IDLE;
                  end else if (go & hwdata[CTL_STOP] & master_q) begin
                     st_q <= S_STOP;
                  end else if (go & hwdata[CTL_START] & master_q) begin
                     st_q <= S_START;
                  end else if (go & ~master_q & ~busy_q) begin
                     st_q <= hwdata[CTL_START] ? S_IDLE : S_IDLE;
                  end else if (go) begin
                     sh_q <= data_q;
                     bit_q <= 4'h0;
                     st_q <= master_q ? S_BIT : S_SBIT;
                  end
               end
               S_START: if (tick) begin
                  // Repeated START is issued without releasing the bus in between.
                  scl_oe_n_q <= 1'b1;
                  if (scl_now & ~sda_oe_n_q) begin
                     scl_oe_n_q <= 1'b0;
                     code_q <= busy_q ? ST_RSTART : ST_START;
                     busy_q <= 1'b1; addr_ph_q <= 1'b1; rx_q <= 1'b0;
                     done_q <= 1'b1; hold_q <= 1'b1;
                     st_q <= S_WAIT;
                  end else if (scl_now) sda_oe_n_q <= 1'b0;
                  else sda_oe_n_q <= 1'b1;
               end
               S_BIT: if (tick) begin
                  // Matching bits from rival masters never trip the check.
                  if (scl_oe_n_q) begin
                     scl_oe_n_q <= 1'b0;
                     if (rx_q) sh_q <= {sh_q[6:0], sda_now};
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h7) st_q <= S_ACK;
                  end else begin
                     sda_oe_n_q <= rx_q ? 1'b1 : sh_q[7 - bit_q[2:0]];
                     scl_oe_n_q <= 1'b1;
                  end
               end
               S_ACK: if (tick) begin
                  if (scl_oe_n_q) begin
                     scl_oe_n_q <= 1'b0;
                     done_q <= 1'b1; hold_q <= 1'b1;
                     if (addr_ph_q) begin
                        rx_q <= sh_q[0];
                        code_q <= sh_q[0] ? (sda_now ? ST_MR_ADR_NAK : ST_MR_ADR_ACK)
                                          : (sda_now ? ST_MT_ADR_NAK : ST_MT_ADR_ACK);
                     end else if (rx_q) begin
                        data_q <= sh_q;
                        code_q <= ack_q ? ST_MR_DAT_ACK : ST_MR_DAT_NAK;
                     end else code_q <= sda_now ? ST_MT_DAT_NAK : ST_MT_DAT_ACK;
                     addr_ph_q <= 1'b0;
                     bit_q <= 4'h0;
                     st_q <= S_WAIT;
                  end else begin
                     sda_oe_n_q <= rx_q ? ~ack_q : 1'b1;
                     scl_oe_n_q <= 1'b1;
                  end
               end
               S_STOP: if (tick) begin
                  if (~scl_oe_n_q & sda_oe_n_q) sda_oe_n_q <= 1'b0;
                  else if (~scl_oe_n_q) scl_oe_n_q <= 1'b1;
                  else begin
                     sda_oe_n_q <= 1'b1;
                     sto_q <= 1'b0;
                     st_q <= S_IDLE;
                  end
               end
               S_SLV: begin
                  bit_q <= 4'h0; addr_ph_q <= 1'b1; rx_q <= 1'b1;
                  if (scl_fall) st_q <= S_SBIT;
               end
               S_SBIT: if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_now};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'h7) st_q <= S_SACK;
               end
               S_SACK: if (scl_fall) begin
                  if (addr_ph_q & (sh_q[7:1] == own_q) & ack_q) begin
                     sda_oe_n_q <= 1'b0;
                     busy_q <= 1'b1;
                     code_q <= sh_q[0] ? (code_q == ST_ARB_LOST ? ST_ST_ARB : ST_ST_ADR)
                                       : (code_q == ST_ARB_LOST ? ST_SR_ARB : ST_SR_ADR);
                  end else if (addr_ph_q) begin
                     code_q <= ST_ARB_LOST;
                     busy_q <= 1'b0;
                  end else data_q <= sh_q;
                  done_q <= 1'b1; hold_q <= 1'b1;
                  addr_ph_q <= 1'b0; bit_q <= 4'h0;
                  st_q <= S_WAIT;
               end
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end

   always_comb begin
      pins.scl_oe_n = scl_oe_n_q;
      pins.sda_oe_n = sda_oe_n_q;
   end
endmodule
`default_nettype wire

// ---- pkg/twbus_pkg.sv ----
// Package for the two-wire bus error and arbitration block.
// Assumes an AHB-Lite register slave with 32-bit words and a 100 MHz hclk.
package twbus_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_DATA   = 8'h08;
   localparam logic [7:0] OFF_ADDR   = 8'h0C;
   localparam logic [7:0] OFF_IRQ_ST = 8'h10;
   localparam logic [7:0] OFF_IRQ_EN = 8'h14;
   localparam logic [7:0] OFF_IRQ_CL = 8'h18;

   // Control register field positions.
   localparam int CTL_EN    = 0;
   localparam int CTL_DONE  = 1;
   localparam int CTL_START = 2;
   localparam int CTL_STOP  = 3;
   localparam int CTL_ACK   = 4;

   // Interrupt status bit positions.
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_BERR  = 1;
   localparam int IRQ_ARB   = 2;
   localparam int IRQ_W     = 3;

   // Status codes.
   localparam logic [7:0] ST_IDLE       = 8'hF8;
   localparam logic [7:0] ST_BUS_ERR    = 8'h00;
   localparam logic [7:0] ST_START      = 8'h08;
   localparam logic [7:0] ST_RSTART     = 8'h10;
   localparam logic [7:0] ST_MT_ADR_ACK = 8'h18;
   localparam logic [7:0] ST_MT_ADR_NAK = 8'h20;
   localparam logic [7:0] ST_MT_DAT_ACK = 8'h28;
   localparam logic [7:0] ST_MT_DAT_NAK = 8'h30;
   localparam logic [7:0] ST_ARB_LOST   = 8'h38;
   localparam logic [7:0] ST_MR_ADR_ACK = 8'h40;
   localparam logic [7:0] ST_MR_ADR_NAK = 8'h48;
   localparam logic [7:0] ST_MR_DAT_ACK = 8'h50;
   localparam logic [7:0] ST_MR_DAT_NAK = 8'h58;
   localparam logic [7:0] ST_SR_ADR     = 8'h60;
   localparam logic [7:0] ST_SR_ARB     = 8'h68;
   localparam logic [7:0] ST_SR_DAT_ACK = 8'h80;
   localparam logic [7:0] ST_SR_DAT_NAK = 8'h88;
   localparam logic [7:0] ST_SR_STOP    = 8'hA0;
   localparam logic [7:0] ST_ST_ADR     = 8'hA8;
   localparam logic [7:0] ST_ST_ARB     = 8'hB0;
   localparam logic [7:0] ST_ST_DAT_ACK = 8'hB8;
   localparam logic [7:0] ST_ST_DAT_NAK = 8'hC0;

   // Bus timing: half period of the generated SCL.
   localparam int HALF_NS     = 5000;
   localparam int CLK_NS      = 10;
   localparam int HALF_CYCLES = HALF_NS / CLK_NS;

   // Main sequencer states.
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0000,
      S_WAIT  = 4'b0001,
      S_START = 4'b0010,
      S_BIT   = 4'b0011,
      S_ACK   = 4'b0100,
      S_STOP  = 4'b0101,
      S_SLV   = 4'b0110,
      S_SBIT  = 4'b0111,
      S_SACK  = 4'b1000
   } seq_e;

   // Open-drain pin pair; oe_n low means the pin is pulled low.
   typedef struct packed {
      logic scl_oe_n;
      logic sda_oe_n;
   } pin_drive_s;

endpackage

// ---- tb/twbus_chk.sv ----
// Checker on the two-wire unit's ports.
// Assumes zero-wait AHB-Lite and pulled-up SCL and SDA.
`timescale 1ns/10ps
`default_nettype none
module twbus_chk #(
   parameter int HALF = 4
)(
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire logic                  hsel,
   input wire logic [31:0]           haddr,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic [2:0]            hsize,
   input wire logic [31:0]           hwdata,
   input wire logic                  hready,
   input wire logic [31:0]           hrdata,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire logic                  scl_in,
   input wire logic                  sda_in,
   input wire twbus_pkg::pin_drive_s pins,
   input wire logic                  irq
);
   import twbus_pkg::*;
   logic [7:0] wa_q;
   logic       wr_q, st_q, hold_q, berr_q;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Write data lands a cycle after its address, so writes are judged on wr_q.
   wire       rd_ap     = hsel & hready & htrans[1] & ~hwrite;
   wire       wr_ap     = hsel & hready & htrans[1] & hwrite;
   wire       done_w    = wr_q && wa_q == OFF_CTRL && hwdata[CTL_DONE];
   wire       recover_w = done_w && hwdata[CTL_STOP] && !hwdata[CTL_START];
   wire [1:0] pin_v     = pins;
   // Flags non-idle and bus-error status reads until a done write or recovery, so holds and recoveries can be judged.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wa_q   <= 8'h00;
         wr_q   <= 1'b0;
         st_q   <= 1'b0;
         hold_q <= 1'b0;
         berr_q <= 1'b0;
      end else begin
         wa_q   <= haddr[7:0];
         wr_q   <= wr_ap;
         st_q   <= rd_ap && haddr[7:0] == OFF_STATUS;
         hold_q <= done_w ? 1'b0 : (st_q && hrdata[7:0] != ST_IDLE) | hold_q;
         berr_q <= recover_w ? 1'b0 : (st_q && hrdata[7:0] == ST_BUS_ERR) | berr_q;
      end
   end
   ready_okay_a: assert property (hreadyout && !hresp)
      else $error("slave stalled or answered with an error");
   rdata_hold_a: assert property (!rd_ap |=> $stable(hrdata))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (rd_ap && haddr[7:0] > OFF_IRQ_CL |=> hrdata == 32'h0)
      else $error("unmapped read gave nonzero data");
   status_code_a: assert property (rd_ap && haddr[7:0] == OFF_STATUS |=> hrdata[31:8] == 24'h0 && hrdata[2:0] == 3'h0)
      else $error("status word outside the code format");
   irq_mask_a: assert property (wr_q && wa_q == OFF_IRQ_EN && hwdata[2:0] == 3'h0 |=> ##1 !irq)
      else $error("interrupt stayed up with all enables off");
   reset_quiet_a: assert property ($rose(hresetn) |-> pin_v == 2'b11 && !irq && hrdata == 32'h0)
      else $error("outputs not quiet after reset");
   recover_free_a: assert property (berr_q && recover_w |=> (pin_v == 2'b11) [*8])
      else $error("lines driven after error recovery");
   scl_hold_a: assert property (hold_q && !pins.scl_oe_n && !done_w |=> !pins.scl_oe_n)
      else $error("clock released before the done write");
endmodule
bind two_wire_unit twbus_chk #(.HALF(HALF)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .scl_in(scl_in), .sda_in(sda_in), .pins(pins), .irq(irq)
);
`default_nettype wire

// ---- tb/twbus_peer.sv ----
// Behavioural peer on the two-wire bus: acks, contends and bit-bangs.
// Assumes the bench resolves SCL and SDA as open drain with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module twbus_peer (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [8:0] pull_mask,
   output logic            scl_low,
   output logic            sda_low,
   output logic [7:0]      stop_cnt
);
   logic       scl_q, sda_q, man_scl_q, man_sda_q;
   logic [3:0] bit_q;
   wire        start_w = scl & scl_q & sda_q & ~sda;
   wire        stop_w  = scl & scl_q & ~sda_q & sda;
   // Bit index in a byte; F marks the gap after a START, before the first fall.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bit_q    <= 4'hF;
         stop_cnt <= 8'h00;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_w) bit_q <= 4'hF;
         else if (scl_q & ~scl) bit_q <= (bit_q == 4'h8 || bit_q == 4'hF) ? 4'h0 : bit_q + 4'h1;
         if (stop_w) stop_cnt <= stop_cnt + 8'h01;
      end
   end
   // Pulls copy a contending byte or the ack slot; a zero wins the wire.
   assign sda_low = man_sda_q | (bit_q < 4'h9 && pull_mask[bit_q]);
   assign scl_low = man_scl_q;
   // Holds both lines for half of the 160 ns bang period.
   task automatic hold(input logic c, input logic d);
      man_scl_q <= c;
      man_sda_q <= d;
      repeat (8) @(posedge hclk);
   endtask
   initial begin
      man_scl_q = 1'b0;
      man_sda_q = 1'b0;
   end
endmodule
`default_nettype wire

// ---- tb/tb_two_wire_unit.sv ----
// Self-checking bench for the two-wire unit beside one peer.
// Assumes the peer and checker files are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module tb_two_wire_unit;
   import twbus_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, p_scl, p_sda;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [8:0]  mask;
   logic [7:0]  stops, s0;
   pin_drive_s  pins;
   int          n_mismatch, check_count;
   // Pull-ups hold each line high unless a party pulls it low.
   wire         scl = pins.scl_oe_n & ~p_scl;
   wire         sda = pins.sda_oe_n & ~p_sda;
   two_wire_unit #(.HALF(8)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .scl_in(scl), .sda_in(sda), .pins(pins), .irq(irq)
   );
   twbus_peer peer (
      .hclk(hclk), .hresetn(hresetn), .scl(scl), .sda(sda), .pull_mask(mask),
      .scl_low(p_scl), .sda_low(p_sda), .stop_cnt(stops)
   );
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Waits for hready under a bound; a stuck bus ends the run.
   task rdy;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 64);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
   endtask
   // One single-word transfer; read data lands in v.
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      rdy();
      v = hrdata;
   endtask
   task rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, v, exp);
   endtask
   task irq_is(input logic e);
      repeat (2) @(posedge hclk);
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask
   // Polls status; every read before the code must show the idle code.
   task wait_st(input logic [7:0] code);
      int i;
      for (i = 0; i < 300; i++) begin
         bus(1'b0, OFF_STATUS, 32'h0);
         if (v[7:0] === code) break;
         chk("status_idle", v, {24'h0, ST_IDLE});
      end
      chk("status", v, {24'h0, code});
      if (i >= 300) close_out();
   endtask
   task t_reset;
      rc("status", OFF_STATUS, {24'h0, ST_IDLE});
      rc("ctrl", OFF_CTRL, 32'h0);
      bus(1'b1, OFF_IRQ_ST, 32'h7);
      rc("irq_st_ro", OFF_IRQ_ST, 32'h0);
      rc("unmapped", 8'h1C, 32'h0);
      irq_is(1'b0);
   endtask
   // A STOP four bits into an address byte must be caught and recovered.
   task t_bus_error;
      bus(1'b1, OFF_IRQ_EN, 32'h2);
      bus(1'b1, OFF_ADDR, 32'h55);
      bus(1'b1, OFF_CTRL, 32'h11);
      peer.hold(1'b0, 1'b1);
      repeat (3) begin
         peer.hold(1'b1, 1'b0);
         peer.hold(1'b0, 1'b0);
      end
      peer.hold(1'b1, 1'b1);
      peer.hold(1'b0, 1'b1);
      peer.hold(1'b0, 1'b0);
      s0 = stops;
      wait_st(ST_BUS_ERR);
      bus(1'b0, OFF_CTRL, 32'h0);
      chk("done_set", {31'h0, v[CTL_DONE]}, 32'h1);
      chk("irq_berr", {31'h0, irq}, 32'h1);
      bus(1'b0, OFF_IRQ_ST, 32'h0);
      chk("berr_bit", {31'h0, v[IRQ_BERR]}, 32'h1);
      bus(1'b1, OFF_CTRL, 32'h1B);
      rc("ctrl_kept", OFF_CTRL, 32'h11);
      repeat (8) @(posedge hclk);
      chk("released", {30'h0, pins}, 32'h3);
      chk("no_stop", {24'h0, stops}, {24'h0, s0});
      rc("status_after", OFF_STATUS, {24'h0, ST_IDLE});
      bus(1'b1, OFF_IRQ_CL, 32'h7);
      irq_is(1'b0);
   endtask
   // Sends one byte once the peer mask is set, then waits for its code.
   task send(input logic [8:0] m, input logic [7:0] d, input logic [7:0] code);
      mask <= m;
      bus(1'b1, OFF_DATA, {24'h0, d});
      bus(1'b1, OFF_CTRL, 32'h03);
      wait_st(code);
   endtask
   task t_master;
      bus(1'b1, OFF_IRQ_EN, 32'h0);
      s0 = stops;
      bus(1'b1, OFF_CTRL, 32'h07);
      wait_st(ST_START);
      send(9'h1FB, 8'h20, ST_MT_ADR_ACK);
      mask <= 9'h000;
      bus(1'b1, OFF_CTRL, 32'h07);
      wait_st(ST_RSTART);
      send(9'h1FB, 8'h20, ST_MT_ADR_ACK);
      // The peer wins at data bit one; it then clocks the rest of the byte itself.
      mask <= 9'h002;
      bus(1'b1, OFF_DATA, 32'hFF);
      bus(1'b1, OFF_CTRL, 32'h03);
      v = 32'h0;
      for (int k = 0; k < 100 && !v[IRQ_ARB]; k++) bus(1'b0, OFF_IRQ_ST, 32'h0);
      chk("arb_seen", {31'h0, v[IRQ_ARB]}, 32'h1);
      repeat (6) begin
         peer.hold(1'b1, 1'b0);
         peer.hold(1'b0, 1'b0);
      end
      peer.hold(1'b1, 1'b0);
      peer.hold(1'b0, 1'b0);
      wait_st(ST_ARB_LOST);
      mask <= 9'h000;
      chk("no_stop", {24'h0, stops}, {24'h0, s0});
      bus(1'b0, OFF_IRQ_ST, 32'h0);
      chk("arb_bit", {31'h0, v[IRQ_ARB]}, 32'h1);
      chk("done_bit", {31'h0, v[IRQ_DONE]}, 32'h1);
      irq_is(1'b0);
      bus(1'b1, OFF_IRQ_EN, 32'h4);
      irq_is(1'b1);
      bus(1'b1, OFF_IRQ_CL, 32'h7);
      irq_is(1'b0);
   endtask
   // Main sequence: every input set at time zero, reset, then the scenarios.
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      mask = 9'h000;
      n_mismatch = 0;
      check_count = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_bus_error();
      t_master();
      close_out();
   end
endmodule
`default_nettype wire
